// File: verilog/mceb_pkg.sv
package mceb_pkg;
  // ****************************************************
  // model register index map
  // ****************************************************
  localparam logic [31:0] MCEB_BANK_BASE   = 32'h0000_0400; // first bank, four indices per bank
  localparam logic [31:0] MCEB_GCAP_IDX    = 32'h0000_0300;
  localparam logic [31:0] MCEB_GSTAT_IDX   = 32'h0000_0301;
  localparam logic [31:0] MCEB_LEG_TYPE    = 32'h0000_0302;
  localparam logic [31:0] MCEB_LEG_LOC     = 32'h0000_0303;
  localparam int          MCEB_BANK_STRIDE = 4;
  localparam logic [1:0]  MCEB_SEL_CTL     = 2'h0;
  localparam logic [1:0]  MCEB_SEL_STATUS  = 2'h1;
  localparam logic [1:0]  MCEB_SEL_LOC     = 2'h2;
  localparam logic [1:0]  MCEB_SEL_EXTRA   = 2'h3;

  // ****************************************************
  // bank status field layout
  // ****************************************************
  localparam int MCEB_CODE_LSB  = 0;
  localparam int MCEB_MODEL_LSB = 16;
  localparam int MCEB_OTHER_LSB = 32;
  localparam int MCEB_OTHER_W   = 25;
  localparam int MCEB_PCC       = 57;
  localparam int MCEB_LOCATION_RECORDED_FLAG     = 58;
  localparam int MCEB_EXTRA_INFO_RECORDED_FLAG     = 59;
  localparam int MCEB_EN        = 60;
  localparam int MCEB_UC        = 61;
  localparam int MCEB_OVER      = 62;
  localparam int MCEB_VAL       = 63;
  localparam int MCEB_LOC_W     = 36;
  localparam int MCEB_CHECK_IN_PROGRESS      = 2;
  localparam int MCEB_ID_ARCH   = 14;
  localparam int MCEB_ID_MCE    = 7;

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [63:0] MCEB_ZERO64    = 64'h0000_0000_0000_0000;
  localparam logic [63:0] MCEB_ONES64    = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [31:0] MCEB_ID_RESULT = 32'h0000_4080; // bits 14 and 7
endpackage

// File: verilog/mceb_bank.sv
`timescale 1ns/1ns
module mceb_bank
  import mceb_pkg::*;
#(
  parameter int NUM_BANKS   = 5,
  parameter int LEGACY_BANK = 0
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 nrst_i,
  input  wire logic                 msr_rd_i,
  input  wire logic                 msr_wr_i,
  input  wire logic [31:0]          msr_idx_i,
  input  wire logic [63:0]          msr_wdata_i,
  input  wire logic                 err_valid_i,
  input  wire logic [7:0]           err_bank_i,
  input  wire logic [5:0]           err_enable_idx_i,
  input  wire logic [15:0]          err_arch_code_i,
  input  wire logic [15:0]          err_model_code_i,
  input  wire logic [MCEB_OTHER_W-1:0] err_other_i,
  input  wire logic                 err_corrupt_i,
  input  wire logic                 err_not_corrected_i,
  input  wire logic                 err_loc_valid_i,
  input  wire logic [MCEB_LOC_W-1:0] err_loc_i,
  input  wire logic                 check_enable_i,
  output logic [63:0]               msr_rdata_o,
  output logic                      msr_rack_o,
  output logic                      msr_fault_o,
  output logic                      check_trap_o,
  output logic                      shutdown_o,
  output logic [31:0]               ident_result_o
);

  // ****************************************************
  // elaboration checks
  // ****************************************************
  generate
    if (NUM_BANKS < 2 || NUM_BANKS > 255 || LEGACY_BANK >= NUM_BANKS) begin : g_bad
      $error("mceb_bank: bank count or legacy bank out of range");
    end
  endgenerate

  localparam int BW = $clog2(NUM_BANKS);

  // ****************************************************
  // reset release
  // ****************************************************
  logic rst_meta;
  logic rst_n;

  // release synchronised so no flop leaves reset on a ragged edge
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************************
  // storage
  // ****************************************************
  logic [63:0]            bank_report_enables [NUM_BANKS];
  logic [63:0]            bank_error_status   [NUM_BANKS];
  logic [MCEB_LOC_W-1:0]  bank_error_location [NUM_BANKS];
  logic                   check_in_progress;

  // ****************************************************
  // index decode
  // ****************************************************
  logic [31:0]   off;
  logic          hit_bank;
  logic [BW-1:0] acc_bank;
  logic [1:0]    acc_sel;
  logic          hit_gcap;
  logic          hit_gstat;

  // legacy indices fold onto the bus-error bank so both names see one record
  always_comb begin
    off       = msr_idx_i - MCEB_BANK_BASE;
    hit_bank  = (msr_idx_i >= MCEB_BANK_BASE) && (off < 32'(NUM_BANKS * MCEB_BANK_STRIDE));
    acc_bank  = off[2 +: BW];
    acc_sel   = off[1:0];
    hit_gcap  = (msr_idx_i == MCEB_GCAP_IDX);
    hit_gstat = (msr_idx_i == MCEB_GSTAT_IDX);
    if (msr_idx_i == MCEB_LEG_TYPE) begin
      hit_bank = 1'b1;
      acc_bank = BW'(LEGACY_BANK);
      acc_sel  = MCEB_SEL_STATUS;
    end else if (msr_idx_i == MCEB_LEG_LOC) begin
      hit_bank = 1'b1;
      acc_bank = BW'(LEGACY_BANK);
      acc_sel  = MCEB_SEL_LOC;
    end
  end

  logic wr_status;
  logic clr_status;
  logic wr_ctl;
  logic wr_bad;

  // a status write with any one bit set is refused and faults
  always_comb begin
    wr_status  = msr_wr_i && hit_bank && (acc_sel == MCEB_SEL_STATUS);
    clr_status = wr_status && (msr_wdata_i == MCEB_ZERO64);
    wr_ctl     = msr_wr_i && hit_bank && (acc_sel == MCEB_SEL_CTL);
    wr_bad     = msr_wr_i && !(clr_status || wr_ctl || hit_gstat);
  end

  // ****************************************************
  // error logging decision
  // ****************************************************
  logic          err_ok;
  logic [BW-1:0] eb;
  logic [63:0]   cur;
  logic          en_bit;
  logic          do_log;
  logic          set_over;
  logic          trap_now;

  // a clear in the same cycle counts as already done: the new error wins
  always_comb begin
    err_ok = err_valid_i && (err_bank_i < 8'(NUM_BANKS));
    eb     = err_bank_i[BW-1:0];
    cur    = bank_error_status[eb];
    if (clr_status && acc_bank == eb) begin
      cur = MCEB_ZERO64;
    end
    en_bit   = bank_report_enables[eb][err_enable_idx_i];
    set_over = err_ok && cur[MCEB_VAL];
    do_log   = err_ok && (!cur[MCEB_VAL] ||
               (!(cur[MCEB_UC] && err_not_corrected_i) &&
                ((en_bit && !cur[MCEB_EN]) ||
                 (err_not_corrected_i && !cur[MCEB_UC]))));
    trap_now = do_log && en_bit && check_enable_i;
  end

  // ****************************************************
  // status and location records
  // ****************************************************
  // logging into an empty bank ignores software setup, so power-up errors stay visible
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        bank_error_status[b]   <= MCEB_ZERO64;
        bank_error_location[b] <= '0;
      end
    end else begin
      if (clr_status) begin
        bank_error_status[acc_bank] <= MCEB_ZERO64;
      end
      if (do_log) begin
        bank_error_status[eb] <= {1'b1,
                                  set_over,
                                  err_not_corrected_i,
                                  en_bit,
                                  1'b0,
                                  err_loc_valid_i,
                                  err_corrupt_i,
                                  err_other_i,
                                  err_model_code_i,
                                  err_arch_code_i};
        bank_error_location[eb] <= err_loc_valid_i ? err_loc_i : '0;
      end else if (set_over) begin
        bank_error_status[eb][MCEB_OVER] <= 1'b1;
      end
    end
  end

  // ****************************************************
  // per-error enables
  // ****************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        bank_report_enables[b] <= MCEB_ZERO64;
      end
    end else if (wr_ctl) begin
      bank_report_enables[acc_bank] <= msr_wdata_i;
    end
  end

  // ****************************************************
  // check in progress, trap and shutdown
  // ****************************************************
  // the trap sets the flag even if software writes it that cycle
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      check_in_progress <= 1'b0;
    end else if (trap_now) begin
      check_in_progress <= 1'b1;
    end else if (msr_wr_i && hit_gstat) begin
      check_in_progress <= msr_wdata_i[MCEB_CHECK_IN_PROGRESS];
    end
  end

  // shutdown holds until reset; nothing short of that recovers the core
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      check_trap_o <= 1'b0;
      shutdown_o   <= 1'b0;
    end else begin
      check_trap_o <= trap_now;
      if (trap_now && check_in_progress) begin
        shutdown_o <= 1'b1;
      end
    end
  end

  // ****************************************************
  // read port and fault
  // ****************************************************
  logic [63:0] rd_mux;

  always_comb begin
    rd_mux = MCEB_ZERO64;
    if (hit_gcap) begin
      rd_mux[7:0] = 8'(NUM_BANKS);
    end else if (hit_gstat) begin
      rd_mux[MCEB_CHECK_IN_PROGRESS] = check_in_progress;
    end else if (hit_bank) begin
      case (acc_sel)
        MCEB_SEL_CTL:    rd_mux = bank_report_enables[acc_bank];
        MCEB_SEL_STATUS: rd_mux = bank_error_status[acc_bank];
        MCEB_SEL_LOC:    rd_mux[MCEB_LOC_W-1:0] = bank_error_location[acc_bank];
        default:         rd_mux = MCEB_ZERO64; // extra info not implemented
      endcase
    end
  end

  // one-cycle answer; unmapped reads fault like refused writes
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      msr_rdata_o <= MCEB_ZERO64;
      msr_rack_o  <= 1'b0;
      msr_fault_o <= 1'b0;
    end else begin
      msr_rack_o  <= msr_rd_i;
      msr_fault_o <= wr_bad || (msr_rd_i && !(hit_bank || hit_gcap || hit_gstat));
      if (msr_rd_i) begin
        msr_rdata_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ident_result_o <= MCEB_ID_RESULT;
    end else begin
      ident_result_o <= MCEB_ID_RESULT;
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  logic          read_loc;
  logic          read_status;
  logic [MCEB_UC:0] cur_low;
  // cur_low is the held record below the overflow flag, which a refused error must not touch
  always_comb begin
    read_loc    = msr_rd_i && hit_bank && acc_sel == MCEB_SEL_LOC;
    read_status = msr_rd_i && hit_bank && acc_sel == MCEB_SEL_STATUS;
    cur_low     = cur[MCEB_UC:0];
  end

  status_write_fault_a: assert property (
    wr_status && msr_wdata_i != MCEB_ZERO64 |=> msr_fault_o)
    else $error("nonzero status write did not fault");
  loc_upper_zero_a: assert property (read_loc |=> msr_rdata_o[63:MCEB_LOC_W] == '0)
    else $error("location upper bits not zero");
  extra_flag_zero_a: assert property (read_status |=> !msr_rdata_o[MCEB_EXTRA_INFO_RECORDED_FLAG])
    else $error("extra info flag set");
  keep_uncorrected_a: assert property (
    err_ok && cur[MCEB_VAL] && cur[MCEB_UC] && err_not_corrected_i
    |-> !do_log ##1 (bank_error_status[$past(eb)][MCEB_UC:0] == $past(cur_low)))
    else $error("uncorrected record overwritten");
  overflow_set_a: assert property (set_over |=> bank_error_status[$past(eb)][MCEB_OVER])
    else $error("overflow not set");
  log_valid_code_a: assert property (
    do_log |=> bank_error_status[$past(eb)][MCEB_VAL] &&
               bank_error_status[$past(eb)][15:0] == $past(err_arch_code_i))
    else $error("logged record wrong");
  disabled_no_trap_a: assert property (err_valid_i && !en_bit |=> !check_trap_o)
    else $error("disabled error trapped");
  second_check_a: assert property (trap_now && check_in_progress |=> shutdown_o)
    else $error("no shutdown on nested check");
  bank_count_a: assert property (
    msr_rd_i && hit_gcap |=> msr_rdata_o[7:0] == 8'(NUM_BANKS))
    else $error("bank count wrong");

  log_cover_c:     cover property (do_log ##1 check_trap_o);
  overflow_cover_c: cover property (set_over && !do_log);
  replace_cover_c: cover property (set_over && do_log);
  shutdown_cover_c: cover property (trap_now && check_in_progress);

endmodule

// File: bench/mceb_err_src.sv
`timescale 1ns/1ns
// ****************************************
// hardware unit reporting detected errors
// ****************************************
module mceb_err_src (
  input  wire logic        clk_sys_i,
  output logic             err_valid_o,
  output logic [7:0]       err_bank_o,
  output logic [5:0]       err_enable_idx_o,
  output logic [15:0]      err_arch_code_o,
  output logic [15:0]      err_model_code_o,
  output logic [24:0]      err_other_o,
  output logic             err_corrupt_o,
  output logic             err_not_corrected_o,
  output logic             err_loc_valid_o,
  output logic [35:0]      err_loc_o
);
  // idle at time zero; a report may come right after reset
  initial begin
    err_valid_o = 1'b0;
    {err_bank_o, err_enable_idx_o, err_arch_code_o, err_model_code_o} = 46'h0;
    {err_other_o, err_corrupt_o, err_not_corrected_o, err_loc_valid_o, err_loc_o} = 64'h0;
  end

  // one-cycle strobe; code and location fields are inverted afterwards so stale data never looks valid
  task automatic report(input logic [7:0] b, input logic [5:0] e, input logic [15:0] c,
                        input logic u, input logic lv, input logic [35:0] l);
    @(negedge clk_sys_i);
    {err_bank_o, err_enable_idx_o, err_arch_code_o, err_model_code_o} = {b, e, c, ~c};
    {err_corrupt_o, err_not_corrected_o, err_loc_valid_o, err_loc_o} = {u, u, lv, l};
    err_other_o = 25'h0A5A5A5;
    err_valid_o = 1'b1;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    err_valid_o = 1'b0;
    {err_arch_code_o, err_model_code_o} = ~{err_arch_code_o, err_model_code_o};
    err_loc_o = ~err_loc_o;
  endtask
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import mceb_pkg::*;
  logic        clk_sys_i, nrst_i, msr_rd_i, msr_wr_i, check_enable_i;
  logic [31:0] msr_idx_i, ident_result_o;
  logic [63:0] msr_wdata_i, msr_rdata_o;
  logic        msr_rack_o, msr_fault_o, check_trap_o, shutdown_o;
  logic        ev, cor, uc, lv;
  logic [7:0]  bk;
  logic [5:0]  ei;
  logic [15:0] ac, mc;
  logic [24:0] ot;
  logic [35:0] lc;
  int          errors, num_checks;

  // ****************************************
  // design and error source
  // ****************************************
  mceb_bank #(.NUM_BANKS(5), .LEGACY_BANK(0)) uut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .msr_rd_i(msr_rd_i), .msr_wr_i(msr_wr_i),
    .msr_idx_i(msr_idx_i), .msr_wdata_i(msr_wdata_i), .err_valid_i(ev), .err_bank_i(bk),
    .err_enable_idx_i(ei), .err_arch_code_i(ac), .err_model_code_i(mc), .err_other_i(ot),
    .err_corrupt_i(cor), .err_not_corrected_i(uc), .err_loc_valid_i(lv), .err_loc_i(lc),
    .check_enable_i(check_enable_i), .msr_rdata_o(msr_rdata_o), .msr_rack_o(msr_rack_o),
    .msr_fault_o(msr_fault_o), .check_trap_o(check_trap_o), .shutdown_o(shutdown_o),
    .ident_result_o(ident_result_o));
  mceb_err_src src (
    .clk_sys_i(clk_sys_i), .err_valid_o(ev), .err_bank_o(bk), .err_enable_idx_o(ei),
    .err_arch_code_o(ac), .err_model_code_o(mc), .err_other_o(ot), .err_corrupt_o(cor),
    .err_not_corrected_o(uc), .err_loc_valid_o(lv), .err_loc_o(lc));

  // ****************************************
  // shared helpers
  // ****************************************
  task automatic fail(input string m);
    errors++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
    num_checks++;
    if (g !== e) fail(m);
  endtask
  // one register access; request held until the taking edge, answer read a cycle later
  task automatic acc(input logic wr, input logic [31:0] idx, input logic [63:0] wd,
                     output logic [63:0] rd, output logic flt);
    @(negedge clk_sys_i);
    {msr_rd_i, msr_wr_i, msr_idx_i, msr_wdata_i} = {~wr, wr, idx, wd};
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rd = msr_rdata_o;
    flt = msr_fault_o;
    if (!wr) chk({63'h0, msr_rack_o}, 64'h1, "read not acknowledged");
    {msr_rd_i, msr_wr_i, msr_idx_i, msr_wdata_i} = {2'b00, ~idx, ~wd};
  endtask
  task automatic rdx(input logic [31:0] idx, input logic [63:0] e, input string m);
    logic [63:0] d;
    logic        f;
    acc(1'b0, idx, 64'h0, d, f);
    chk(d, e, m);
    chk({63'h0, f}, 64'h0, "read faulted");
  endtask
  task automatic wrx(input logic [31:0] idx, input logic [63:0] w, input logic ef, input string m);
    logic [63:0] d;
    logic        f;
    acc(1'b1, idx, w, d, f);
    chk({63'h0, f}, {63'h0, ef}, m);
  endtask
  // expected status word; the source flags corruption exactly when uncorrected
  function automatic logic [63:0] st(input logic [15:0] c, input logic en, u, ov, l);
    return {1'b1, ov, u, en, 1'b0, l, u, 25'h0A5A5A5, ~c, c};
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk({32'h0, ident_result_o}, 64'h0000_0000_0000_4080, "ident result");
    rdx(32'h0000_0300, 64'h0000_0000_0000_0005, "bank count");
    rdx(32'h0000_0405, 64'h0, "status after reset");
    $display("test reset done");
  endtask
  task automatic t_log();
    wrx(32'h0000_0404, 64'hFFFF_FFFF_FFFF_FFFF, 1'b0, "enable write");
    check_enable_i = 1'b1;
    src.report(8'h01, 6'h07, 16'h0135, 1'b1, 1'b1, 36'hF_1234_5678);
    chk({63'h0, check_trap_o}, 64'h1, "no trap");
    rdx(32'h0000_0405, st(16'h0135, 1'b1, 1'b1, 1'b0, 1'b1), "status");
    rdx(32'h0000_0405, st(16'h0135, 1'b1, 1'b1, 1'b0, 1'b1), "status flags");
    rdx(32'h0000_0405, st(16'h0135, 1'b1, 1'b1, 1'b0, 1'b1), "status valid");
    rdx(32'h0000_0406, 64'h0000_000F_1234_5678, "location");
    rdx(32'h0000_0407, 64'h0, "extra reads zero");
    rdx(32'h0000_0301, 64'h0000_0000_0000_0004, "in progress");
    wrx(32'h0000_0301, 64'h0, 1'b0, "clear progress");
    $display("test log done");
  endtask
  task automatic t_write();
    logic [63:0] d;
    logic        f;
    wrx(32'h0000_0405, 64'h0000_0000_0000_0001, 1'b1, "low bit write");
    wrx(32'h0000_0405, 64'h8000_0000_0000_0000, 1'b1, "high bit write");
    rdx(32'h0000_0405, st(16'h0135, 1'b1, 1'b1, 1'b0, 1'b1), "status kept");
    wrx(32'h0000_0406, 64'h0, 1'b1, "location write");
    acc(1'b0, 32'h0000_0500, 64'h0, d, f);
    chk({63'h0, f}, 64'h1, "unmapped read");
    wrx(32'h0000_0405, 64'h0, 1'b0, "zero write");
    rdx(32'h0000_0405, 64'h0, "cleared");
    $display("test write done");
  endtask
  // enable bit 0 only: step order disabled, enabled, enabled, uncorrected, uncorrected
  task automatic t_prio();
    int k;
    check_enable_i = 1'b0;
    wrx(32'h0000_040C, 64'h0000_0000_0000_0001, 1'b0, "enable bit");
    for (int i = 0; i < 5; i++) begin
      src.report(8'h03, (i == 0 || i == 3) ? 6'h05 : 6'h00, 16'((i + 1) * 17),
                 1'(5'b11000 >> i), 1'b0, 36'h0);
      k = (i == 2 || i == 4) ? i - 1 : i;
      rdx(32'h0000_040D, st(16'((k + 1) * 17), 1'(5'b00110 >> k), 1'(5'b11000 >> k),
          1'(5'b11110 >> i), 1'b0), "overwrite");
    end
    $display("test priority done");
  endtask
  task automatic t_legacy();
    check_enable_i = 1'b1;
    src.report(8'h00, 6'h01, 16'h0C0F, 1'b0, 1'b1, 36'h0_0000_ABCD);
    chk({63'h0, check_trap_o}, 64'h0, "disabled error trapped");
    rdx(32'h0000_0401, st(16'h0C0F, 1'b0, 1'b0, 1'b0, 1'b1), "bank zero");
    rdx(32'h0000_0302, st(16'h0C0F, 1'b0, 1'b0, 1'b0, 1'b1), "legacy type");
    rdx(32'h0000_0303, 64'h0000_0000_0000_ABCD, "legacy location");
    wrx(32'h0000_0302, 64'h0000_0000_0000_0001, 1'b1, "legacy type write");
    wrx(32'h0000_0302, 64'h0, 1'b0, "legacy clear");
    rdx(32'h0000_0401, 64'h0, "bank zero cleared");
    $display("test legacy done");
  endtask
  task automatic t_stop();
    wrx(32'h0000_0410, 64'hFFFF_FFFF_FFFF_FFFF, 1'b0, "enable bank four");
    wrx(32'h0000_0301, 64'h0000_0000_0000_0004, 1'b0, "set progress");
    src.report(8'h04, 6'h00, 16'h0001, 1'b1, 1'b0, 36'h0);
    chk({63'h0, shutdown_o}, 64'h1, "no shutdown");
    $display("test shutdown done");
  endtask

  // ****************************************
  // verdict, clock, watchdog, sequence
  // ****************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // the whole sequence needs under a hundred cycles
  initial begin
    #100000;
    fail("watchdog expired");
    conclude();
  end
  initial begin
    {nrst_i, msr_rd_i, msr_wr_i, check_enable_i} = 4'h0;
    {msr_idx_i, msr_wdata_i} = 96'h0;
    errors = 0;
    num_checks = 0;
    repeat (5) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    t_reset();
    t_log();
    t_write();
    t_prio();
    t_legacy();
    t_stop();
    conclude();
  end
endmodule
